// ### eep_pkg.sv
/*
 * Constants, states and carrier types for the serial EEPROM command port.
 * Assumes a 200 MHz system clock and a host that clocks the serial link.
 */
package eep_pkg;

    localparam int ADDR_W      = 10;
    localparam int DATA_W      = 16;
    localparam int WORDS       = 1024;
    localparam int PAGE_W      = 3;
    localparam int PAGE_WORDS  = 8;
    localparam int CNT_W       = 4;
    localparam int PROG_CNT_W  = 20;

    // Leading six opcode bits, followed by address bits 9 and 8
    localparam logic [5:0] OP_WORD_PROG = 6'h29;
    localparam logic [5:0] OP_PAGE_PROG = 6'h2d;
    localparam logic [5:0] OP_READ      = 6'h2a;
    localparam logic [7:0] OP_PROG_EN   = 8'ha3;
    localparam logic [7:0] OP_PROG_DIS  = 8'ha0;

    localparam logic [3:0]  LAST_BIT    = 4'hf;
    localparam logic [15:0] ERASED_WORD = 16'hffff;

    localparam int CLK_FREQ_MHZ = 200;
    localparam int PROG_TIME_MS = 5;
    localparam int PROG_CYCLES  = PROG_TIME_MS * CLK_FREQ_MHZ * 1000;

    typedef enum logic [2:0] {
        LK_IDLE = 3'h0,
        LK_HDR  = 3'h1,
        LK_DATA = 3'h2,
        LK_READ = 3'h3,
        LK_DONE = 3'h4
    } eep_link_t;

    // Levels and toggles passed from the link side to the system clock
    typedef struct packed {
        logic selN;
        logic abort;
        logic progTgl;
        logic cmdTgl;
        logic cmdEnable;
        logic armed;
        logic seq;
    } eep_xing_t;

endpackage

// ### eep_sync2.sv
/*
 * Two flip-flop synchroniser for a vector of independent levels.
 * Assumes each bit is a level or a toggle that holds for several edges.
 */
`timescale 1ns/100ps
module eep_sync2 #(
    parameter int WIDTH = 1
) (
    input  wire logic             clock,
    input  wire logic             rst_n,
    input  wire logic [WIDTH-1:0] asyncIn,
    output logic      [WIDTH-1:0] syncOut
);

    logic [WIDTH-1:0] meta_ff;
    logic [WIDTH-1:0] sync_ff;

    // First stage feeds only the second stage
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            meta_ff <= '0;
            sync_ff <= '0;
        end
        else
        begin
            meta_ff <= asyncIn;
            sync_ff <= meta_ff;
        end
    end

    assign syncOut = sync_ff;

endmodule

// ### eep_command_port.sv
/*
 * Command port of a 1024 x 16 serial EEPROM: framing, decode, read stream,
 * word and page program with a self-timed period, ready/busy and abort.
 * Assumes the host clocks serialClockIn only while selected and keeps
 * select high between frames; the array is modelled by flip-flops.
 */
// Behaviour
// R1: Sample serial input on every rising serial clock edge.
// R2: Shift read data out on falling serial clock edges.
// R3: Frame is opcode byte, address byte, then sixteen data bits.
// R4: Select falling with serial clock high starts instruction receive.
// R5: Select falling with serial clock low starts status output.
// R6: Status output lasts until select rises or leading opcode one arrives.
// R7: Data output floats except during status output or read data.
// R8: Select rising mid instruction aborts that instruction.
// R9: Ready output low exactly while self-timed programming runs.
// R10: Instructions are ignored while programming runs.
// R11: Enable latch cleared at reset and by disable, set by enable.
// R12: Reads execute whatever the enable latch holds.
// R13: Read, enable and disable ignore the abort input.
// R14: No programming starts while the abort input is high.
// R15: Abort input high during programming ends it, word left indeterminate.
// R16: Host raises select after an abort before a new instruction.
// R17: Host keeps select high at least 250 ns between instructions.
// R18: Word, page and read opcodes carry address bits 9 and 8.
// R19: Enable and disable opcodes take an ignored address byte, no data.
// R20: Word program starts on the 32nd rising serial clock edge.
// R21: Self-timed programming, with erase, finishes within 5 ms.
// R22: Array holds 1024 words of 16 bits, ten-bit address.
// R23: Page program wraps within an eight-word page on low three bits.
// R24: Page program starts when select rises right after a full word.
// R25: Read output starts at 17th falling edge, most significant bit first.
// R26: Continued read clocking streams words, address wrapping at the top.
`timescale 1ns/100ps
module eep_command_port #(
    parameter int PROG_CYCLES = eep_pkg::PROG_CYCLES
) (
    input  wire logic clock,
    input  wire logic rst_n,
    input  wire logic serialClockIn,
    input  wire logic selectN,
    input  wire logic serialIn,
    input  wire logic writeResetIn,
    output logic      dataOut,
    output logic      dataOeN,
    output logic      readyOut
);

    localparam logic [eep_pkg::PROG_CNT_W-1:0] PROG_LAST =
        eep_pkg::PROG_CNT_W'(PROG_CYCLES - 1);

    // Array, written on the system clock, read by the link
    logic [eep_pkg::DATA_W-1:0] mem_ff [eep_pkg::WORDS];

    // Link side, frame scope: cleared whenever select is high
    logic                          linkRstN;
    eep_pkg::eep_link_t            state_ff;
    logic [eep_pkg::DATA_W-1:0]    shift_ff;
    logic [eep_pkg::CNT_W-1:0]     cnt_ff;
    logic [eep_pkg::PAGE_W-1:0]    slot_ff;
    logic                          isPage_ff;
    logic                          statusFlag_ff;
    logic [eep_pkg::ADDR_W-1:0]    rdAddr_ff;
    logic                          sawFall_ff;
    logic                          rdOn_ff;
    logic [eep_pkg::CNT_W-1:0]     rdIdx_ff;
    logic [eep_pkg::ADDR_W-1:0]    rdPtr_ff;
    logic [eep_pkg::DATA_W-1:0]    rdWord_ff;
    logic                          rdBit_ff;

    // Link side, persistent across frames
    logic [eep_pkg::DATA_W-1:0]    pageBuf_ff [eep_pkg::PAGE_WORDS];
    logic [eep_pkg::PAGE_WORDS-1:0] mask_ff;
    logic [eep_pkg::ADDR_W-eep_pkg::PAGE_W-1:0] pageHigh_ff;
    logic                          progTgl_ff;
    logic                          cmdTgl_ff;
    logic                          cmdEnable_ff;
    logic                          armed_ff;
    logic                          seq_ff;
    logic                          busyLink;

    // Decode strobes on the link clock
    logic [eep_pkg::DATA_W-1:0]    full;
    logic [7:0]                    opcode;
    logic                          hdrLast;
    logic                          dataLast;
    logic                          progDecode;
    logic                          cmdDecode;
    logic                          readDecode;
    logic                          statusOn;
    logic [eep_pkg::DATA_W-1:0]    nextWord;

    // System side
    eep_pkg::eep_xing_t            xin;
    eep_pkg::eep_xing_t            xs;
    logic                          prevSelN_ff;
    logic                          prevProg_ff;
    logic                          prevCmd_ff;
    logic                          lastSeq_ff;
    logic                          enable_ff;
    logic                          ready_ff;
    logic [eep_pkg::PROG_CNT_W-1:0] progCnt_ff;
    logic                          progEvt;
    logic                          pageEvt;
    logic                          cmdEvt;
    logic                          progStart;
    logic                          progDone;
    logic                          progAbort;

    assign linkRstN = rst_n & selectN == 1'b0;  // see R8

    assign full    = {shift_ff[eep_pkg::DATA_W-2:0], serialIn};
    assign opcode  = full[15:8];
    assign hdrLast = state_ff == eep_pkg::LK_HDR &&
                     cnt_ff == eep_pkg::LAST_BIT;
    assign dataLast = state_ff == eep_pkg::LK_DATA &&
                      cnt_ff == eep_pkg::LAST_BIT;

    assign progDecode = hdrLast && !busyLink &&
                        (opcode[7:2] == eep_pkg::OP_WORD_PROG ||
                         opcode[7:2] == eep_pkg::OP_PAGE_PROG);  // see R18
    assign cmdDecode  = hdrLast && !busyLink &&
                        (opcode == eep_pkg::OP_PROG_EN ||
                         opcode == eep_pkg::OP_PROG_DIS);  // see R19
    assign readDecode = hdrLast && !busyLink &&
                        opcode[7:2] == eep_pkg::OP_READ;  // see R10

    // Busy level into the link domain; a frame gives it 16 edges to settle
    eep_sync2 #(
        .WIDTH (1)
    ) u_busy_sync (
        .clock   (serialClockIn),
        .rst_n   (rst_n),
        .asyncIn (~ready_ff),
        .syncOut (busyLink)
    );

    // Frame receive on rising edges
    always_ff @(posedge serialClockIn or negedge linkRstN)
    begin
        if (!linkRstN)
        begin
            state_ff      <= eep_pkg::LK_IDLE;
            shift_ff      <= '0;
            cnt_ff        <= '0;
            slot_ff       <= '0;
            isPage_ff     <= 1'b0;
            statusFlag_ff <= 1'b0;
            rdAddr_ff     <= '0;
        end
        else
        begin
            shift_ff <= full;  // see R1
            cnt_ff   <= cnt_ff + 4'h1;
            if (!sawFall_ff)
            begin
                statusFlag_ff <= 1'b1;  // see R5
            end
            unique case (state_ff)
                eep_pkg::LK_IDLE:
                begin
                    cnt_ff <= 4'h1;
                    if (serialIn)
                    begin
                        state_ff <= eep_pkg::LK_HDR;  // see R6
                    end
                end
                eep_pkg::LK_HDR:
                begin
                    if (hdrLast)
                    begin
                        isPage_ff <= opcode[4];
                        slot_ff   <= full[eep_pkg::PAGE_W-1:0];
                        rdAddr_ff <= full[eep_pkg::ADDR_W-1:0];
                        if (progDecode)
                        begin
                            state_ff <= eep_pkg::LK_DATA;  // see R3
                        end
                        else if (readDecode)
                        begin
                            state_ff <= eep_pkg::LK_READ;  // see R12
                        end
                        else
                        begin
                            state_ff <= eep_pkg::LK_DONE;
                        end
                    end
                end
                eep_pkg::LK_DATA:
                begin
                    if (dataLast)
                    begin
                        slot_ff <= slot_ff + 3'h1;  // see R23
                        if (!isPage_ff)
                        begin
                            state_ff <= eep_pkg::LK_DONE;
                        end
                    end
                end
                eep_pkg::LK_READ,
                eep_pkg::LK_DONE:
                begin
                    cnt_ff <= cnt_ff;
                end
                default:
                begin
                    state_ff <= eep_pkg::LK_DONE;
                end
            endcase
        end
    end

    // Page buffer and events that must outlive the frame
    always_ff @(posedge serialClockIn or negedge rst_n)
    begin
        if (!rst_n)
        begin
            mask_ff      <= '0;
            pageHigh_ff  <= '0;
            progTgl_ff   <= 1'b0;
            cmdTgl_ff    <= 1'b0;
            cmdEnable_ff <= 1'b0;
            armed_ff     <= 1'b0;
            seq_ff       <= 1'b0;
            for (int i = 0; i < eep_pkg::PAGE_WORDS; i++)
            begin
                pageBuf_ff[i] <= '0;
            end
        end
        else
        begin
            // Armed only while no edge has followed a complete page word
            armed_ff <= dataLast && isPage_ff;  // see R24
            if (progDecode)
            begin
                mask_ff     <= '0;
                pageHigh_ff <= full[eep_pkg::ADDR_W-1:eep_pkg::PAGE_W];
                // One toggle per page frame; a per-word toggle cancels out
                // on an even word count and the page would never start
                if (opcode[7:2] == eep_pkg::OP_PAGE_PROG)
                begin
                    seq_ff <= !seq_ff;
                end
            end
            if (dataLast)
            begin
                pageBuf_ff[slot_ff] <= full;
                mask_ff[slot_ff]    <= 1'b1;
                if (!isPage_ff)
                begin
                    progTgl_ff <= !progTgl_ff;  // see R20
                end
            end
            if (cmdDecode)
            begin
                cmdTgl_ff    <= !cmdTgl_ff;
                cmdEnable_ff <= opcode == eep_pkg::OP_PROG_EN;  // see R19
            end
        end
    end

    // The array word under the read pointer is static during a read, since
    // programming cannot start while a read frame is open
    assign nextWord = mem_ff[rdPtr_ff + 10'h1];

    // Read stream on falling edges
    always_ff @(negedge serialClockIn or negedge linkRstN)
    begin
        if (!linkRstN)
        begin
            sawFall_ff <= 1'b0;
            rdOn_ff    <= 1'b0;
            rdIdx_ff   <= '0;
            rdPtr_ff   <= '0;
            rdWord_ff  <= '0;
            rdBit_ff   <= 1'b0;
        end
        else
        begin
            sawFall_ff <= 1'b1;
            if (state_ff == eep_pkg::LK_READ && !rdOn_ff)
            begin
                rdOn_ff   <= 1'b1;  // see R25
                rdPtr_ff  <= rdAddr_ff;
                rdWord_ff <= mem_ff[rdAddr_ff];
                rdBit_ff  <= mem_ff[rdAddr_ff][eep_pkg::DATA_W-1];
                rdIdx_ff  <= 4'h1;
            end
            else if (rdOn_ff && rdIdx_ff == 4'h0)
            begin
                rdPtr_ff  <= rdPtr_ff + 10'h1;  // see R26
                rdWord_ff <= nextWord;
                rdBit_ff  <= nextWord[eep_pkg::DATA_W-1];
                rdIdx_ff  <= 4'h1;
            end
            else if (rdOn_ff)
            begin
                rdBit_ff <= rdWord_ff[eep_pkg::LAST_BIT - rdIdx_ff];  // see R2
                rdIdx_ff <= rdIdx_ff + 4'h1;
            end
        end
    end

    // Status shows before the first edge only if the clock idles low
    assign statusOn = !selectN && state_ff == eep_pkg::LK_IDLE &&
                      (statusFlag_ff ||
                       (!sawFall_ff && !serialClockIn));  // see R4
    assign dataOeN  = !(statusOn || rdOn_ff);  // see R7
    assign dataOut  = statusOn ? ready_ff : rdBit_ff;  // see R5
    assign readyOut = ready_ff;  // see R9

    // Crossing into the system clock; armed and seq settle before selN rises, but cmdEnable changes on the same edge as cmdTgl
    always_comb
    begin
        xin           = '0;
        xin.selN      = selectN;
        xin.abort     = writeResetIn;
        xin.progTgl   = progTgl_ff;
        xin.cmdTgl    = cmdTgl_ff;
        xin.cmdEnable = cmdEnable_ff;
        xin.armed     = armed_ff;
        xin.seq       = seq_ff;
    end

    eep_sync2 #(
        .WIDTH ($bits(eep_pkg::eep_xing_t))
    ) u_sys_sync (
        .clock   (clock),
        .rst_n   (rst_n),
        .asyncIn (xin),
        .syncOut (xs)
    );

    assign progEvt   = xs.progTgl != prevProg_ff;
    assign cmdEvt    = xs.cmdTgl != prevCmd_ff;
    assign pageEvt   = xs.selN && !prevSelN_ff && xs.armed &&
                       xs.seq != lastSeq_ff;  // see R24
    assign progStart = (progEvt || pageEvt) && enable_ff &&
                       !xs.abort && ready_ff;  // see R14
    assign progAbort = !ready_ff && xs.abort;  // see R15
    assign progDone  = !ready_ff && !xs.abort &&
                       progCnt_ff == PROG_LAST;  // see R21

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            prevSelN_ff <= 1'b0;
            prevProg_ff <= 1'b0;
            prevCmd_ff  <= 1'b0;
            lastSeq_ff  <= 1'b0;
        end
        else
        begin
            prevSelN_ff <= xs.selN;
            prevProg_ff <= xs.progTgl;
            prevCmd_ff  <= xs.cmdTgl;
            if (xs.selN && !prevSelN_ff)
            begin
                lastSeq_ff <= xs.seq;
            end
        end
    end

    // Enable latch; commands arriving while busy are dropped
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            enable_ff <= 1'b0;  // see R11
        end
        else if (cmdEvt && ready_ff)
        begin
            enable_ff <= xs.cmdEnable;  // see R13
        end
    end

    // Self-timed program period
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ready_ff   <= 1'b1;
            progCnt_ff <= '0;
        end
        else if (progStart)
        begin
            ready_ff   <= 1'b0;  // see R9
            progCnt_ff <= '0;
        end
        else if (progAbort || progDone)
        begin
            ready_ff   <= 1'b1;  // see R15
            progCnt_ff <= '0;
        end
        else if (!ready_ff)
        begin
            progCnt_ff <= progCnt_ff + 20'h1;
        end
    end

    // Erase at start, fill at the end; an abort leaves words erased
    always_ff @(posedge clock)
    begin
        for (int i = 0; i < eep_pkg::PAGE_WORDS; i++)
        begin
            if (mask_ff[i] && progStart)
            begin
                mem_ff[{pageHigh_ff, 3'(i)}] <= eep_pkg::ERASED_WORD;
            end
            else if (mask_ff[i] && progDone)
            begin
                mem_ff[{pageHigh_ff, 3'(i)}] <= pageBuf_ff[i];  // see R22
            end
        end
    end

endmodule

// ### eep_command_port_properties.sv
/*
 * Pin level checks for the serial EEPROM command port.
 * Assumes it is bound to eep_command_port and sees only its ports.
 */
`timescale 1ns/100ps
module eep_command_port_properties #(
    parameter int PROG_CYCLES = eep_pkg::PROG_CYCLES
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic serialClockIn,
    input wire logic selectN,
    input wire logic serialIn,
    input wire logic writeResetIn,
    input wire logic dataOut,
    input wire logic dataOeN,
    input wire logic readyOut
);
    int unsigned busyCnt;
    logic        abortSeen;

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    // Busy length kept in a counter, far too long for a repetition
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n || readyOut)
        begin
            busyCnt   <= 0;
            abortSeen <= 1'b0;
        end
        else
        begin
            busyCnt   <= busyCnt + 1;
            abortSeen <= abortSeen | writeResetIn;
        end
    end

    sequence busyAbortS;
        !readyOut && writeResetIn;
    endsequence
    sequence busyEndS;
        $rose(readyOut) && !abortSeen;
    endsequence
    sequence statusStartS;
        $fell(selectN) && !serialClockIn;
    endsequence

    float_off_a: assert property (selectN |-> dataOeN)
        else $error("data output driven while deselected");
    status_drive_a: assert property (statusStartS |->
        !dataOeN && dataOut == readyOut)
        else $error("status mode did not show ready state");
    abort_ready_a: assert property (busyAbortS |-> ##[1:4] readyOut)
        else $error("abort did not end programming");
    busy_max_a: assert property (!readyOut |-> busyCnt <= PROG_CYCLES + 1)
        else $error("programming ran too long");
    busy_min_a: assert property (busyEndS |-> busyCnt + 2 >= PROG_CYCLES)
        else $error("programming ended early");
    reset_protect_a: assert property ($fell(readyOut) |->
        !$past(writeResetIn, 3))
        else $error("programming began while reset input high");
    oe_edge_a: assert property ($fell(dataOeN) |-> !serialClockIn)
        else $error("output enabled with serial clock high");
    shift_edge_a: assert property (!dataOeN && !$past(dataOeN)
        && $changed(dataOut) |-> !serialClockIn)
        else $error("read data changed with serial clock high");
endmodule

bind eep_command_port eep_command_port_properties #(
    .PROG_CYCLES(PROG_CYCLES)
) chk (
    .clock(clock),
    .rst_n(rst_n),
    .serialClockIn(serialClockIn),
    .selectN(selectN),
    .serialIn(serialIn),
    .writeResetIn(writeResetIn),
    .dataOut(dataOut),
    .dataOeN(dataOeN),
    .readyOut(readyOut)
);

// ### eep_host_model.sv
/*
 * Host serial port model: clocks the link inside frames; a status frame also drops the clock before select falls and raises it after select rises.
 * Assumes the bench calls its tasks one at a time.
 */
`timescale 1ns/100ps
module eep_host_model (
    output logic     serialClockIn,
    output logic     selectN,
    output logic     serialIn,
    input wire logic dataOut,
    input wire logic dataOeN
);
    initial
    begin
        serialClockIn = 1'b1;
        selectN       = 1'b1;
        serialIn      = 1'b0;
    end

    // Clock high at select fall frames, clock low asks for status
    task automatic open_frame(input logic clkLevel);
        serialClockIn = clkLevel;
        #20;
        selectN = 1'b0;
        #20;
    endtask

    // Long gap also covers the device synchronisers
    task automatic close_frame();
        #20;
        selectN  = 1'b1;
        serialIn = ~serialIn;
        #20;
        serialClockIn = 1'b1;
        #260;
    endtask

    // Floating output reads as unknown so it never passes for data
    task automatic shift(input logic [31:0] bitsOut, input int n,
                         output logic [15:0] bitsIn);
        bitsIn = 16'h0;
        for (int i = n - 1; i >= 0; i--)
        begin
            serialClockIn = 1'b0;
            serialIn      = bitsOut[i];
            #16;
            if (i < 16)
                bitsIn[i] = dataOeN ? 1'bx : dataOut;
            serialClockIn = 1'b1;
            #16;
        end
    endtask
endmodule

// ### eep_command_port_tb.sv
/*
 * Self-checking bench for the serial EEPROM command port.
 * Assumes the host model drives the link and the checker is bound.
 */
`timescale 1ns/100ps
module eep_command_port_tb;
    localparam int PROG = 400;
    logic        clock;
    logic        rst_n;
    logic        writeResetIn;
    logic        serialClockIn;
    logic        selectN;
    logic        serialIn;
    wire         dataOut;
    wire         dataOeN;
    wire         readyOut;
    int          bad_count;
    int          samples_checked;
    logic [15:0] got;

    eep_command_port #(.PROG_CYCLES(PROG)) dut (
        .clock(clock), .rst_n(rst_n), .serialClockIn(serialClockIn),
        .selectN(selectN), .serialIn(serialIn),
        .writeResetIn(writeResetIn), .dataOut(dataOut),
        .dataOeN(dataOeN), .readyOut(readyOut));
    eep_host_model host (
        .serialClockIn(serialClockIn), .selectN(selectN),
        .serialIn(serialIn), .dataOut(dataOut), .dataOeN(dataOeN));

    always #2.5 clock = ~clock;

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        #1;
        samples_checked++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic cmd(input logic [7:0] op, input logic [7:0] adr);
        host.open_frame(1'b1);
        host.shift({16'h0, op, adr}, 16, got);
        host.close_frame();
    endtask

    task automatic write_word(input logic [9:0] a, input logic [15:0] d);
        host.open_frame(1'b1);
        host.shift({eep_pkg::OP_WORD_PROG, a, d}, 32, got);
        host.close_frame();
    endtask

    task automatic read_check(input logic [9:0] a, input logic [15:0] e[$]);
        host.open_frame(1'b1);
        host.shift({16'h0, eep_pkg::OP_READ, a}, 16, got);
        foreach (e[k])
        begin
            host.shift(32'h0, 16, got);
            check(got, e[k]);
        end
        host.close_frame();
    endtask

    // Bounded so a stuck busy ends as a mismatch, not a hang
    task automatic wait_ready();
        for (int n = 0; n < PROG + 50 && readyOut !== 1'b1; n++)
            @(posedge clock);
        check(readyOut, 1'b1);
    endtask

    task automatic t_status();
        host.open_frame(1'b0);
        check({dataOeN, dataOut}, 2'b01);
        host.shift(32'h1, 2, got);
        check(got[1:0], 2'b11);
        check(dataOeN, 1'b1);
        host.close_frame();
        check(dataOeN, 1'b1);
    endtask

    task automatic t_protect();
        write_word(10'h155, 16'h1234);
        check(readyOut, 1'b1);
        @(posedge clock) writeResetIn <= 1'b1;
        cmd(eep_pkg::OP_PROG_EN, 8'h00);
        write_word(10'h155, 16'h1234);
        check(readyOut, 1'b1);
        @(posedge clock) writeResetIn <= 1'b0;
        write_word(10'h155, 16'h1234);
        check(readyOut, 1'b0);
        host.open_frame(1'b0);
        check({dataOeN, dataOut}, 2'b00);
        host.close_frame();
        host.open_frame(1'b1);
        host.shift({eep_pkg::OP_READ, 10'h155, 16'h0}, 32, got);
        host.close_frame();
        check(got, 16'hxxxx);
        wait_ready();
        read_check(10'h155, {16'h1234});
    endtask

    task automatic t_page();
        logic [15:0] e[$];
        write_word(10'h000, 16'h0f0f);
        wait_ready();
        host.open_frame(1'b1);
        host.shift({16'h0, eep_pkg::OP_PAGE_PROG, 10'h3fe}, 16, got);
        for (int k = 0; k < 10; k++)
            host.shift({16'h0, 16'ha000 + 16'(k)}, 16, got);
        host.close_frame();
        check(readyOut, 1'b0);
        wait_ready();
        // Start slot 6: words 8 and 9 land again on slots 6 and 7
        for (int s = 0; s < 8; s++)
            e.push_back(16'ha000 + 16'((s + 2) % 8 + (s >= 6 ? 8 : 0)));
        e.push_back(16'h0f0f);
        cmd(eep_pkg::OP_PROG_DIS, 8'hff);
        write_word(10'h000, 16'h5555);
        check(readyOut, 1'b1);
        read_check(10'h3f8, e);
    endtask

    task automatic t_abort();
        cmd(eep_pkg::OP_PROG_EN, 8'h00);
        host.open_frame(1'b1);
        host.shift({12'h0, eep_pkg::OP_WORD_PROG, 10'h001, 4'h0}, 20, got);
        host.close_frame();
        check(readyOut, 1'b1);
        write_word(10'h002, 16'hbeef);
        repeat (20) @(posedge clock);
        writeResetIn <= 1'b1;
        repeat (5) @(posedge clock);
        check(readyOut, 1'b1);
        @(posedge clock) writeResetIn <= 1'b0;
        read_check(10'h155, {16'h1234});
    endtask

    // Reset in mid program must end busy and clear the enable latch
    task automatic t_reset();
        write_word(10'h003, 16'h0000);
        check(readyOut, 1'b0);
        @(posedge clock) rst_n <= 1'b0;
        repeat (8) @(posedge clock);
        rst_n <= 1'b1;
        check(readyOut, 1'b1);
        repeat (3) @(posedge clock);
        write_word(10'h155, 16'h0000);
        check(readyOut, 1'b1);
        read_check(10'h155, {16'h1234});
    endtask

    task automatic wrap_up();
        $display("Mismatches %0d, comparisons %0d", bad_count,
                 samples_checked);
        if (bad_count == 0 && samples_checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    initial
    begin
        clock           = 1'b0;
        rst_n           = 1'b0;
        writeResetIn    = 1'b0;
        bad_count       = 0;
        samples_checked = 0;
        repeat (8) @(posedge clock);
        rst_n <= 1'b1;
        repeat (3) @(posedge clock);
        t_status();
        t_protect();
        t_page();
        t_abort();
        t_reset();
        wrap_up();
    end

    // Whole run needs about 40 us of link traffic
    initial
    begin
        #100000;
        bad_count++;
        wrap_up();
    end
endmodule
